// File: verilog/adc_result_pkg.sv
// Package for the conversion result and monitor compare register bank.
// Assumes a single system clock domain and an APB register bus.
package adc_result_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_RESULT_E = 8'h00;
  localparam logic [7:0] OFF_RESULT_F = 8'h04;
  localparam logic [7:0] OFF_PRIORITY = 8'h08;
  localparam logic [7:0] OFF_THRESHOLD = 8'h0c;
  localparam logic [7:0] OFF_MON_MODE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int RES_MSB = 15;
  localparam int RES_LSB = 6;
  localparam int OVR_BIT = 1;
  localparam int STORED_BIT = 0;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_DIR_BIT = 2;
  localparam int MODE_EN_BIT = 3;
  localparam int IRQ_MON_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [9:0] RESET_RESULT = 10'h000;
  localparam logic [1:0] RESET_IRQ = 2'h0;

  // Monitor register select encodings
  localparam logic [1:0] SEL_E = 2'h0;
  localparam logic [1:0] SEL_F = 2'h1;
  localparam logic [1:0] SEL_PRIORITY = 2'h2;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [9:0] value;
    logic overrun;
    logic stored;
  } result_slot_t;

  typedef struct packed {
    logic enable;
    logic above;
    logic [1:0] select;
  } monitor_mode_t;

  typedef struct packed {
    logic valid;
    logic [1:0] slot;
    logic [9:0] value;
  } result_write_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ACCESS = 2'b01
  } apb_state_t;

endpackage

// File: verilog/result_slot.sv
// One conversion result slot with stored and overrun flags.
// Assumes writes come from the sequencer and read clears come from the bus.
`timescale 1ns/1ps
module result_slot (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic write_en,
  input wire logic [9:0] write_value,
  input wire logic read_clear,
  output adc_result_pkg::result_slot_t slot
);

  adc_result_pkg::result_slot_t slot_q;
  adc_result_pkg::result_slot_t slot_d;

  // ==========================================================================
  // Next state: a store in the same cycle as a read wins over the stored clear; the overrun clear still holds
  always_comb begin
    slot_d = slot_q;
    if (read_clear) begin
      slot_d.overrun = 1'b0;
      slot_d.stored = 1'b0;
    end
    if (write_en) begin
      slot_d.value = write_value;
      slot_d.stored = 1'b1;
      if (slot_q.stored && !read_clear) begin
        slot_d.overrun = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slot_q <= '{value: adc_result_pkg::RESET_RESULT, overrun: 1'b0, stored: 1'b0};
    end else begin
      slot_q <= slot_d;
    end
  end

  assign slot = slot_q;

endmodule

// File: verilog/adc_result_regs.sv
// Conversion result and monitor compare register bank, APB slave.
// Assumes the conversion sequencer drives one result write per cycle at most.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module adc_result_regs (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_result_pkg::result_write_t result_write,
  output logic monitor_interrupt_zero,
  output logic irq
);

  // ==========================================================================
  // Functions
  function automatic logic [31:0] pack_slot(input adc_result_pkg::result_slot_t s);
    logic [31:0] w;
    w = adc_result_pkg::RESET_WORD;
    w[adc_result_pkg::RES_MSB:adc_result_pkg::RES_LSB] = s.value;
    w[adc_result_pkg::OVR_BIT] = s.overrun;
    w[adc_result_pkg::STORED_BIT] = s.stored;
    return w;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == adc_result_pkg::OFF_RESULT_E) || (a == adc_result_pkg::OFF_RESULT_F) ||
      (a == adc_result_pkg::OFF_PRIORITY) || (a == adc_result_pkg::OFF_THRESHOLD) ||
      (a == adc_result_pkg::OFF_MON_MODE) || (a == adc_result_pkg::OFF_IRQ_STATUS) ||
      (a == adc_result_pkg::OFF_IRQ_MASK);
  endfunction

  // ==========================================================================
  // Bus state
  adc_result_pkg::apb_state_t state_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic access_done;
  logic rd_e;
  logic rd_f;
  logic rd_p;
  logic wr_ok;
  logic bad_access;

  // Slave answers one cycle into the access phase
  assign access_done = psel && penable && (state_q == adc_result_pkg::APB_ACCESS);
  // Byte-only writes are refused; halfword or word lanes must include bits 15:0
  assign bad_access = !is_mapped(paddr) ||
    (pwrite && !(pstrb[0] && pstrb[1]));
  assign wr_ok = access_done && pwrite && !bad_access;
  assign rd_e = access_done && !pwrite && (paddr == adc_result_pkg::OFF_RESULT_E);
  assign rd_f = access_done && !pwrite && (paddr == adc_result_pkg::OFF_RESULT_F);
  assign rd_p = access_done && !pwrite && (paddr == adc_result_pkg::OFF_PRIORITY);

  // ==========================================================================
  // Result slots
  adc_result_pkg::result_slot_t slot_e;
  adc_result_pkg::result_slot_t slot_f;
  adc_result_pkg::result_slot_t slot_p;
  logic we_e;
  logic we_f;
  logic we_p;

  assign we_e = result_write.valid && (result_write.slot == adc_result_pkg::SEL_E);
  assign we_f = result_write.valid && (result_write.slot == adc_result_pkg::SEL_F);
  // Only top-priority results route here
  assign we_p = result_write.valid &&
    (result_write.slot == adc_result_pkg::SEL_PRIORITY);

  result_slot u_slot_e (
    .clk_sys(clk_sys),
    .reset(reset),
    .write_en(we_e),
    .write_value(result_write.value),
    .read_clear(rd_e),
    .slot(slot_e)
  );

  result_slot u_slot_f (
    .clk_sys(clk_sys),
    .reset(reset),
    .write_en(we_f),
    .write_value(result_write.value),
    .read_clear(rd_f),
    .slot(slot_f)
  );

  result_slot u_slot_p (
    .clk_sys(clk_sys),
    .reset(reset),
    .write_en(we_p),
    .write_value(result_write.value),
    .read_clear(rd_p),
    .slot(slot_p)
  );

  // ==========================================================================
  // Threshold and monitor mode
  logic [9:0] threshold_value_zero_q;
  adc_result_pkg::monitor_mode_t monitor_mode_register_zero_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      threshold_value_zero_q <= adc_result_pkg::RESET_RESULT;
    end else if (wr_ok && paddr == adc_result_pkg::OFF_THRESHOLD) begin
      // Written regardless of enable; software must disable the monitor first
      threshold_value_zero_q <=
        pwdata[adc_result_pkg::RES_MSB:adc_result_pkg::RES_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      monitor_mode_register_zero_q <= '0;
    end else if (wr_ok && paddr == adc_result_pkg::OFF_MON_MODE) begin
      monitor_mode_register_zero_q <= pwdata[adc_result_pkg::MODE_EN_BIT:0];
    end
  end

  // ==========================================================================
  // Monitor compare, evaluated on a store into the selected slot
  logic mon_store;
  logic mon_hit;

  always_comb begin
    mon_store = 1'b0;
    case (monitor_mode_register_zero_q.select)
      adc_result_pkg::SEL_E: mon_store = we_e;
      adc_result_pkg::SEL_F: mon_store = we_f;
      adc_result_pkg::SEL_PRIORITY: mon_store = we_p;
      default: mon_store = 1'b0;
    endcase
  end

  always_comb begin
    mon_hit = 1'b0;
    if (monitor_mode_register_zero_q.enable && mon_store) begin
      if (monitor_mode_register_zero_q.above) begin
        mon_hit = result_write.value > threshold_value_zero_q;
      end else begin
        mon_hit = result_write.value < threshold_value_zero_q;
      end
    end
  end

  // ==========================================================================
  // Interrupt status, mask and output
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_event;
  logic mon_pulse_q;
  logic irq_q;

  assign irq_event = {(we_e && slot_e.stored) || (we_f && slot_f.stored) ||
    (we_p && slot_p.stored), mon_hit};

  // Write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status_q <= adc_result_pkg::RESET_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_ok && paddr == adc_result_pkg::OFF_IRQ_STATUS) ?
        pwdata[1:0] : 2'h0)) | irq_event;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_mask_q <= adc_result_pkg::RESET_IRQ;
    end else if (wr_ok && paddr == adc_result_pkg::OFF_IRQ_MASK) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_q <= 1'b0;
      mon_pulse_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
      mon_pulse_q <= mon_hit;
    end
  end

  assign irq = irq_q;
  assign monitor_interrupt_zero = mon_pulse_q;

  // ==========================================================================
  // APB slave: one wait state, then answer
  logic [31:0] rd_word;

  always_comb begin
    rd_word = adc_result_pkg::RESET_WORD;
    case (paddr)
      adc_result_pkg::OFF_RESULT_E: rd_word = pack_slot(slot_e);
      adc_result_pkg::OFF_RESULT_F: rd_word = pack_slot(slot_f);
      adc_result_pkg::OFF_PRIORITY: rd_word = pack_slot(slot_p);
      adc_result_pkg::OFF_THRESHOLD:
        rd_word[adc_result_pkg::RES_MSB:adc_result_pkg::RES_LSB] = threshold_value_zero_q;
      adc_result_pkg::OFF_MON_MODE: rd_word[3:0] = monitor_mode_register_zero_q;
      adc_result_pkg::OFF_IRQ_STATUS: rd_word[1:0] = irq_status_q;
      adc_result_pkg::OFF_IRQ_MASK: rd_word[1:0] = irq_mask_q;
      default: rd_word = adc_result_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= adc_result_pkg::APB_IDLE;
    end else if (access_done) begin
      state_q <= adc_result_pkg::APB_IDLE;
    end else if (psel && penable) begin
      state_q <= adc_result_pkg::APB_ACCESS;
    end else begin
      state_q <= adc_result_pkg::APB_IDLE;
    end
  end

  // Read data is latched the cycle before pready, so the read clear hits
  // on the completing edge without racing the value returned
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= adc_result_pkg::RESET_WORD;
    end else begin
      pready_q <= psel && penable && (state_q == adc_result_pkg::APB_IDLE) && !pready_q;
      pslverr_q <= psel && penable && (state_q == adc_result_pkg::APB_IDLE) && !pready_q &&
        bad_access;
      if (psel && penable && !pwrite && (state_q == adc_result_pkg::APB_IDLE)) begin
        prdata_q <= bad_access ? adc_result_pkg::RESET_WORD : rd_word;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

// File: tb/adc_result_regs_monitor.sv
// Checker for the result and monitor register bank.
// Sees only top-level ports; bound to the design below.
`timescale 1ns/1ps
module adc_result_regs_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adc_result_pkg::result_write_t result_write,
  input wire logic monitor_interrupt_zero,
  input wire logic irq
);
  // ==========
  // Shadow state
  logic [9:0] val_q [3];
  logic [2:0] st_q;
  logic [2:0] ov_q;
  logic [9:0] thr_q;
  logic [3:0] mode_q;
  wire done = psel && penable && pready && !pslverr;
  wire rd = done && !pwrite && paddr < 8'h0c && paddr[1:0] == 2'h0;
  wire [1:0] ri = paddr[3:2];
  wire [1:0] ws = result_write.slot;
  wire [9:0] wv = result_write.value;
  wire st_in = result_write.valid && ws != 2'h3;
  wire hit = !reset && st_in && mode_q[3] && mode_q[1:0] == ws &&
    (mode_q[2] ? wv > thr_q : wv < thr_q);
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (reset) begin
        val_q[i] <= 10'h000;
        st_q[i] <= 1'b0;
        ov_q[i] <= 1'b0;
      end else if (st_in && ws == 2'(i)) begin
        val_q[i] <= wv;
        st_q[i] <= 1'b1;
        // Read on the same edge wins over overrun
        ov_q[i] <= st_q[i] && !(rd && ri == 2'(i));
      end else if (rd && ri == 2'(i)) begin
        st_q[i] <= 1'b0;
        ov_q[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      thr_q <= 10'h000;
      mode_q <= 4'h0;
    end else if (done && pwrite && paddr == 8'h0c) begin
      thr_q <= pwdata[15:6];
    end else if (done && pwrite && paddr == 8'h10) begin
      mode_q <= pwdata[3:0];
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_byte_refused: assert property (
    pready && psel && pwrite && pstrb[1:0] != 2'b11 |-> pslverr) else $error("byte write taken");
  chk_result_pad: assert property (
    rd |-> prdata[31:16] == 16'h0 && prdata[5:2] == 4'h0) else $error("result pad set");
  chk_result_value: assert property (
    rd |-> prdata[15:6] == $past(val_q[ri])) else $error("result value wrong");
  chk_result_flags: assert property (
    rd |-> prdata[1:0] == {$past(ov_q[ri]), $past(st_q[ri])}) else $error("flags wrong");
  chk_threshold_read: assert property (
    done && !pwrite && paddr == 8'h0c |-> prdata == {16'h0, $past(thr_q), 6'h0})
    else $error("threshold wrong");
  chk_monitor_hit: assert property (hit |=> monitor_interrupt_zero)
    else $error("hit missed");
  chk_monitor_cause: assert property (monitor_interrupt_zero |-> $past(hit))
    else $error("spurious hit");
  chk_reset_quiet: assert property (disable iff (1'b0)
    reset |=> prdata == 32'h0 && !pready && !irq && !monitor_interrupt_zero)
    else $error("reset not quiet");
endmodule
bind adc_result_regs adc_result_regs_monitor adc_result_regs_monitor_inst (
  .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .result_write, .monitor_interrupt_zero, .irq
);

// File: tb/conv_seq_model.sv
// Conversion sequencer model: one result store per call.
// Caller enters store right after a rising clock edge.
`timescale 1ns/1ps
module conv_seq_model (
  input wire logic clk_sys,
  output adc_result_pkg::result_write_t result_write
);
  initial result_write = '0;
  // ==========
  // Store pulse; idle lines show inverted data so stale values never match
  task automatic store(input logic [1:0] s, input logic [9:0] v);
    result_write <= '{valid: 1'b1, slot: s, value: v};
    @(posedge clk_sys);
    result_write <= '{valid: 1'b0, slot: ~s, value: ~v};
    @(posedge clk_sys);
  endtask
endmodule

// File: tb/adc_result_regs_tb.sv
// Self-checking bench for the result and monitor register bank.
// Drives APB itself; the sequencer model feeds conversion results.
`timescale 1ns/1ps
module adc_result_regs_tb;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq, mon, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  adc_result_pkg::result_write_t result_write;
  int fail_count = 0;
  int checks_done = 0;
  typedef struct packed {logic [1:0] slot; logic [9:0] val; logic [31:0] word;} row_t;
  row_t rows [3] = '{'{2'h0, 10'h3ff, 32'h0000ffc1}, '{2'h1, 10'h001, 32'h00000041},
    '{2'h2, 10'h2aa, 32'h0000aa81}};
  adc_result_regs adc_result_regs_inst (
    .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .result_write, .monitor_interrupt_zero(mon), .irq
  );
  conv_seq_model conv_seq_model_inst (.clk_sys, .result_write);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========
  // Tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    // A hung slave is counted here; the run still ends in final_report
    if (n == 20) begin
      fail_count++;
      $display("Error at %0t: pready got %h expected %h", $time, pready, 1'b1);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf, rdata, err);
    chk(rdata, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, rdata, err);
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, irq}, {31'h0, v});
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ==========
  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    do_reset();
    for (int i = 0; i < 3; i++) begin
      conv_seq_model_inst.store(rows[i].slot, rows[i].val);
      rd({4'h0, rows[i].slot, 2'b00}, rows[i].word);
      rd({4'h0, rows[i].slot, 2'b00}, rows[i].word & 32'hffff_fffc);
    end
    $display("test table done");
    conv_seq_model_inst.store(2'h1, 10'h155);
    conv_seq_model_inst.store(2'h1, 10'h0f0);
    rd(8'h04, 32'h00003c03);
    rd(8'h04, 32'h00003c00);
    $display("test overrun done");
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0000ffc0);
    apb(1'b1, 8'h0c, 32'h0, 4'h1, rdata, err);
    chk({31'h0, err}, 32'h1);
    rd(8'h0c, 32'h0000ffc0);
    apb(1'b0, 8'h1c, 32'h0, 4'hf, rdata, err);
    chk(rdata, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test threshold done");
    wr(8'h10, 32'h0);
    apb(1'b1, 8'h0c, 32'h00004000, 4'h3, rdata, err);
    chk({31'h0, err}, 32'h0);
    rd(8'h0c, 32'h00004000);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h1);
    wr(8'h10, 32'hd);
    conv_seq_model_inst.store(2'h1, 10'h200);
    wait_irq(1'b1);
    rd(8'h04, 32'h00008001);
    wr(8'h14, 32'h1);
    wait_irq(1'b0);
    wr(8'h18, 32'h0);
    conv_seq_model_inst.store(2'h1, 10'h300);
    conv_seq_model_inst.store(2'h0, 10'h3ff);
    rd(8'h14, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test monitor done");
    conv_seq_model_inst.store(2'h2, 10'h111);
    do_reset();
    for (int a = 0; a < 20; a += 4) rd(8'(a), 32'h0);
    $display("test reset done");
    final_report();
  end
endmodule
